/* File: core/mfh_function_handler.sv */
// Slave function-code interpreter: receive, check, execute, reply
`timescale 1ns/100ps
module mfh_function_handler #(
   parameter int unsigned GAP_CYCLES = mfh_pkg::GAP_CYCLES  // Idle cycles ending a packet
) (
   input  wire logic        clk_i,            // 125 MHz clock
   input  wire logic        srst_i,           // Synchronous reset, high
   input  wire logic [7:0]  rx_byte_i,        // Received byte
   input  wire logic        rx_valid_i,       // Received byte strobe
   input  wire logic [7:0]  slave_addr_i,     // Own slave address
   input  wire logic        any_addr_i,       // Accept any non-broadcast address
   output logic      [7:0]  tx_byte_o,        // Reply byte
   output logic             tx_valid_o,       // Reply byte valid
   input  wire logic        tx_ready_i,       // Reply byte taken
   output logic      [15:0] reg_addr_o,       // Register address
   output logic      [15:0] reg_wdata_o,      // Register write data
   output logic             reg_we_o,         // Register write pulse
   output logic             reg_re_o,         // Register read pulse
   input  wire logic [15:0] reg_rdata_i,      // Read data, cycle after read pulse
   output logic             op_reset_o,       // Reset operation pulse
   output logic             op_clr_events_o,  // Clear event records pulse
   output logic             op_clr_osc_o,     // Clear oscillography pulse
   output logic      [63:0] vin_state_o       // Virtual input states
);

   mfh_pkg::mfh_state_t state_r;
   logic [7:0]  rx_mem [0:255];
   logic [7:0]  tx_mem [0:255];
   logic [8:0]  len_r;
   logic [15:0] crc_rx_r;
   logic [19:0] gap_r;
   logic [8:0]  tx_len_r;
   logic [8:0]  idx_r;
   logic [15:0] crc_tx_r;
   logic        src_rx_r;
   logic        respond_r;
   logic [7:0]  cnt_r;
   logic [1:0]  phase_r;
   logic [7:0]  tx_byte_r;
   logic        tx_valid_r;
   logic [15:0] reg_addr_r;
   logic [15:0] reg_wdata_r;
   logic        reg_we_r;
   logic        reg_re_r;
   logic        op_reset_r;
   logic        op_clr_events_r;
   logic        op_clr_osc_r;
   logic [63:0] vin_r;

   // Request fields
   wire [7:0]  f_addr = rx_mem[0];
   wire [7:0]  f_fc   = rx_mem[1];
   wire [15:0] f_a    = {rx_mem[2], rx_mem[3]};
   wire [15:0] f_q    = {rx_mem[4], rx_mem[5]};
   wire [7:0]  f_bc   = rx_mem[6];

   // Frame acceptance
   wire gap_done = (gap_r >= 20'(GAP_CYCLES - 1)) && (len_r != 9'h000) && !rx_valid_i;
   wire crc_ok   = (crc_rx_r == 16'h0000) && (len_r >= mfh_pkg::LEN_MIN);
   wire bcast    = f_addr == mfh_pkg::ADDR_BCAST;
   wire hit      = !bcast && (any_addr_i || f_addr == slave_addr_i);
   wire frame_ok = crc_ok && (hit || (bcast && f_fc == mfh_pkg::FC_EXEC));

   // Function decode
   wire is_rd    = f_fc == mfh_pkg::FC_RD_HOLD || f_fc == mfh_pkg::FC_RD_INPUT;
   wire is_ex    = f_fc == mfh_pkg::FC_EXEC;
   wire is_w1    = f_fc == mfh_pkg::FC_WR_ONE;
   wire is_wm    = f_fc == mfh_pkg::FC_WR_MULTI;
   wire fc_known = is_rd || is_ex || is_w1 || is_wm;
   wire len_fix  = len_r == mfh_pkg::LEN_FIXED;
   wire rd_ok    = len_fix && f_q != 16'h0000 && f_q <= mfh_pkg::RD_MAX;
   wire wm_ok    = f_q != 16'h0000 && f_q <= mfh_pkg::WR_MAX && f_bc == {f_q[6:0], 1'b0}
                   && len_r == mfh_pkg::LEN_WR_HDR + {1'b0, f_bc};
   wire op_vin   = f_a >= mfh_pkg::OP_VIN_FIRST && f_a <= mfh_pkg::OP_VIN_LAST;
   wire op_known = op_vin || f_a == mfh_pkg::OP_NONE || f_a == mfh_pkg::OP_RESET
                   || f_a == mfh_pkg::OP_CLR_EVT || f_a == mfh_pkg::OP_CLR_OSC;
   wire val_ok   = f_q == mfh_pkg::VAL_ON || f_q == mfh_pkg::VAL_OFF;
   wire req_ok   = fc_known
                   && (is_rd ? rd_ok : is_ex ? (len_fix && val_ok && op_known) : is_w1 ? len_fix : wm_ok);

   // Error code selection
   wire [7:0] exc_code = !fc_known ? mfh_pkg::EXC_BAD_FUNC :
                         (is_ex && len_fix && val_ok) ? mfh_pkg::EXC_BAD_ADDR : mfh_pkg::EXC_BAD_VALUE;

   // Read and write positions
   wire [7:0]  rd_pos  = 8'(mfh_pkg::LEN_RD_HDR + {cnt_r, 1'b0});
   wire [7:0]  wr_pos  = 8'(mfh_pkg::WR_DATA_POS + {cnt_r[6:0], 1'b0});
   wire        last    = {8'h00, cnt_r} + 16'h0001 == f_q;
   wire [15:0] cur_adr = f_a + {8'h00, cnt_r};

   // Reply byte selection
   wire [7:0]  pay_byte = src_rx_r ? rx_mem[idx_r[7:0]] : tx_mem[idx_r[7:0]];
   wire        tx_adv   = !tx_valid_r || tx_ready_i;
   wire [15:0] crc_nxt  = mfh_pkg::crc_step(crc_tx_r, pay_byte);

   // Receive buffer
   always_ff @(posedge clk_i) begin
      if (state_r == mfh_pkg::ST_RX && rx_valid_i && !len_r[8]) begin
         rx_mem[len_r[7:0]] <= rx_byte_i;
      end
   end

   // Main sequencer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_r         <= mfh_pkg::ST_RX;
         len_r           <= 9'h000;
         crc_rx_r        <= mfh_pkg::CRC_INIT;
         gap_r           <= 20'h00000;
         tx_len_r        <= 9'h000;
         idx_r           <= 9'h000;
         crc_tx_r        <= mfh_pkg::CRC_INIT;
         src_rx_r        <= 1'b0;
         respond_r       <= 1'b0;
         cnt_r           <= 8'h00;
         phase_r         <= 2'h0;
         tx_byte_r       <= 8'h00;
         tx_valid_r      <= 1'b0;
         reg_addr_r      <= 16'h0000;
         reg_wdata_r     <= 16'h0000;
         reg_we_r        <= 1'b0;
         reg_re_r        <= 1'b0;
         op_reset_r      <= 1'b0;
         op_clr_events_r <= 1'b0;
         op_clr_osc_r    <= 1'b0;
         vin_r           <= 64'h0000000000000000;
      end else begin
         reg_we_r        <= 1'b0;
         reg_re_r        <= 1'b0;
         op_reset_r      <= 1'b0;
         op_clr_events_r <= 1'b0;
         op_clr_osc_r    <= 1'b0;
         case (state_r)
            mfh_pkg::ST_RX: begin
               if (rx_valid_i) begin
                  gap_r <= 20'h00000;
                  if (!len_r[8]) begin
                     len_r    <= len_r + 9'h001;
                     crc_rx_r <= mfh_pkg::crc_step(crc_rx_r, rx_byte_i);
                  end
               end else if (gap_done) begin
                  state_r <= mfh_pkg::ST_DECODE;
               end else if (len_r != 9'h000) begin
                  gap_r <= gap_r + 20'h00001;
               end
            end
            mfh_pkg::ST_DECODE: begin
               len_r     <= 9'h000;
               crc_rx_r  <= mfh_pkg::CRC_INIT;
               gap_r     <= 20'h00000;
               cnt_r     <= 8'h00;
               phase_r   <= 2'h0;
               idx_r     <= 9'h000;
               crc_tx_r  <= mfh_pkg::CRC_INIT;
               respond_r <= !bcast;
               if (!frame_ok) begin
                  state_r <= mfh_pkg::ST_RX;
               end else if (!req_ok) begin
                  tx_mem[0] <= f_addr;
                  tx_mem[1] <= f_fc | mfh_pkg::EXC_FLAG;
                  tx_mem[2] <= exc_code;
                  tx_len_r  <= mfh_pkg::LEN_EXC;
                  src_rx_r  <= 1'b0;
                  state_r   <= bcast ? mfh_pkg::ST_RX : mfh_pkg::ST_SEND;
               end else if (is_rd) begin
                  tx_mem[0] <= f_addr;
                  tx_mem[1] <= f_fc;
                  tx_mem[2] <= {f_q[6:0], 1'b0};
                  tx_len_r  <= mfh_pkg::LEN_RD_HDR + {f_q[7:0], 1'b0};
                  src_rx_r  <= 1'b0;
                  state_r   <= mfh_pkg::ST_READ;
               end else begin
                  tx_len_r <= mfh_pkg::LEN_ECHO;
                  src_rx_r <= 1'b1;
                  if (is_ex) begin
                     op_reset_r      <= f_a == mfh_pkg::OP_RESET;
                     op_clr_events_r <= f_a == mfh_pkg::OP_CLR_EVT;
                     op_clr_osc_r    <= f_a == mfh_pkg::OP_CLR_OSC;
                     if (op_vin) begin
                        vin_r[f_a[5:0]] <= f_q == mfh_pkg::VAL_ON;
                     end
                     state_r <= bcast ? mfh_pkg::ST_RX : mfh_pkg::ST_SEND;
                  end else if (is_w1) begin
                     reg_we_r    <= 1'b1;
                     reg_addr_r  <= f_a;
                     reg_wdata_r <= f_q;
                     state_r     <= mfh_pkg::ST_SEND;
                  end else begin
                     state_r <= mfh_pkg::ST_WRITE;
                  end
               end
            end
            mfh_pkg::ST_READ: begin
               if (phase_r == 2'h0) begin
                  reg_re_r   <= 1'b1;
                  reg_addr_r <= cur_adr;
                  phase_r    <= 2'h1;
               end else if (phase_r == 2'h1) begin
                  phase_r <= 2'h2;
               end else begin
                  tx_mem[rd_pos]         <= reg_rdata_i[15:8];
                  tx_mem[8'(rd_pos + 1)] <= reg_rdata_i[7:0];
                  cnt_r                  <= cnt_r + 8'h01;
                  phase_r                <= 2'h0;
                  if (last) begin
                     state_r <= mfh_pkg::ST_SEND;
                  end
               end
            end
            mfh_pkg::ST_WRITE: begin
               reg_we_r    <= 1'b1;
               reg_addr_r  <= cur_adr;
               reg_wdata_r <= {rx_mem[wr_pos], rx_mem[8'(wr_pos + 1)]};
               cnt_r       <= cnt_r + 8'h01;
               if (last) begin
                  state_r <= mfh_pkg::ST_SEND;
               end
            end
            mfh_pkg::ST_SEND: begin
               if (tx_adv) begin
                  if (idx_r < tx_len_r) begin
                     tx_byte_r  <= pay_byte;
                     crc_tx_r   <= crc_nxt;
                     tx_valid_r <= 1'b1;
                     idx_r      <= idx_r + 9'h001;
                  end else if (idx_r == tx_len_r) begin
                     tx_byte_r  <= crc_tx_r[7:0];
                     tx_valid_r <= 1'b1;
                     idx_r      <= idx_r + 9'h001;
                  end else if (idx_r == tx_len_r + 9'h001) begin
                     tx_byte_r  <= crc_tx_r[15:8];
                     tx_valid_r <= 1'b1;
                     idx_r      <= idx_r + 9'h001;
                  end else begin
                     tx_valid_r <= 1'b0;
                     state_r    <= mfh_pkg::ST_RX;
                  end
               end
            end
            default: begin
               state_r <= mfh_pkg::ST_RX;
            end
         endcase
      end
   end

   // Outputs straight from flops
   assign tx_byte_o       = tx_byte_r;
   assign tx_valid_o      = tx_valid_r;
   assign reg_addr_o      = reg_addr_r;
   assign reg_wdata_o     = reg_wdata_r;
   assign reg_we_o        = reg_we_r;
   assign reg_re_o        = reg_re_r;
   assign op_reset_o      = op_reset_r;
   assign op_clr_events_o = op_clr_events_r;
   assign op_clr_osc_o    = op_clr_osc_r;
   assign vin_state_o     = vin_r;

   // Checks
   a_bad_crc_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_r == mfh_pkg::ST_DECODE && !crc_ok) |=> state_r == mfh_pkg::ST_RX && !tx_valid_r && !reg_we_r)
      else $error("bad CRC frame was acted upon");
   a_gap_ends_frame: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_r == mfh_pkg::ST_RX && gap_done) |=> state_r == mfh_pkg::ST_DECODE)
      else $error("dead time did not end the packet");
   a_bcast_silent: assert property (@(posedge clk_i) disable iff (srst_i)
      tx_valid_r |-> respond_r)
      else $error("reply sent to a broadcast");
   a_exc_unsupported: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_r == mfh_pkg::ST_DECODE && frame_ok && !fc_known)
      |=> tx_mem[1] == ($past(f_fc) | mfh_pkg::EXC_FLAG) && tx_mem[2] == mfh_pkg::EXC_BAD_FUNC)
      else $error("unsupported code not answered with error 01");
   a_read_count: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_r == mfh_pkg::ST_DECODE && frame_ok && req_ok && is_rd)
      |=> tx_mem[2] == {$past(f_q[6:0]), 1'b0} && state_r == mfh_pkg::ST_READ)
      else $error("read byte count wrong");
   a_read_limit: assert property (@(posedge clk_i) disable iff (srst_i)
      reg_re_r |-> {8'h00, cnt_r} < mfh_pkg::RD_MAX)
      else $error("more than 125 registers read");
   a_write_limit: assert property (@(posedge clk_i) disable iff (srst_i)
      (reg_we_r && $past(state_r) == mfh_pkg::ST_WRITE) |-> {8'h00, cnt_r} <= mfh_pkg::WR_MAX)
      else $error("more than 60 registers written");
   a_reset_cause: assert property (@(posedge clk_i) disable iff (srst_i)
      op_reset_r |-> $past(state_r) == mfh_pkg::ST_DECODE && $past(f_a) == mfh_pkg::OP_RESET)
      else $error("reset pulse without reset opcode");
   a_bad_count_exc: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_r == mfh_pkg::ST_DECODE && frame_ok && is_rd && f_q == 16'h0000)
      |=> tx_mem[2] == mfh_pkg::EXC_BAD_VALUE && !reg_re_r ##1 !reg_re_r)
      else $error("zero count not refused");

endmodule

/* File: core/mfh_pkg.sv */
// Constants, types and helper functions for the function-code handler
package mfh_pkg;

   // Supported function codes
   localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
   localparam logic [7:0]  FC_RD_INPUT   = 8'h04;
   localparam logic [7:0]  FC_EXEC       = 8'h05;
   localparam logic [7:0]  FC_WR_ONE     = 8'h06;
   localparam logic [7:0]  FC_WR_MULTI   = 8'h10;

   // Exception marking and error codes
   localparam logic [7:0]  EXC_FLAG      = 8'h80;
   localparam logic [7:0]  EXC_BAD_FUNC  = 8'h01;
   localparam logic [7:0]  EXC_BAD_ADDR  = 8'h02;
   localparam logic [7:0]  EXC_BAD_VALUE = 8'h03;

   // Addressing
   localparam logic [7:0]  ADDR_BCAST    = 8'h00;

   // Count limits
   localparam logic [15:0] RD_MAX        = 16'h007D;
   localparam logic [15:0] WR_MAX        = 16'h003C;

   // Operation codes and code values for the execute function
   localparam logic [15:0] OP_NONE       = 16'h0000;
   localparam logic [15:0] OP_RESET      = 16'h0001;
   localparam logic [15:0] OP_CLR_EVT    = 16'h0005;
   localparam logic [15:0] OP_CLR_OSC    = 16'h0006;
   localparam logic [15:0] OP_VIN_FIRST  = 16'h1000;
   localparam logic [15:0] OP_VIN_LAST   = 16'h103F;
   localparam logic [15:0] VAL_ON        = 16'hFF00;
   localparam logic [15:0] VAL_OFF       = 16'h0000;

   // Frame lengths in bytes, CRC included for requests, excluded for replies
   localparam logic [8:0]  LEN_MIN       = 9'h004;
   localparam logic [8:0]  LEN_FIXED     = 9'h008;
   localparam logic [8:0]  LEN_WR_HDR    = 9'h009;
   localparam logic [8:0]  LEN_ECHO      = 9'h006;
   localparam logic [8:0]  LEN_EXC       = 9'h003;
   localparam logic [8:0]  LEN_RD_HDR    = 9'h003;
   localparam logic [7:0]  WR_DATA_POS   = 8'h07;

   // CRC-16, reflected polynomial
   localparam logic [15:0] CRC_INIT      = 16'hFFFF;
   localparam logic [15:0] CRC_POLY      = 16'hA001;

   // Dead time: 3.5 characters at 19200 bit/s is about 2 ms
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          GAP_TIME_NS   = 2000000;
   localparam int          GAP_CYCLES    = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {ST_RX, ST_DECODE, ST_READ, ST_WRITE, ST_SEND} mfh_state_t;

   // One byte through the CRC, low bit first
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

endpackage

/* File: testbench/mfh_master_model.sv */
// Bus master model: sends request frames, takes reply bytes
`timescale 1ns/100ps
module mfh_master_model (
   input  wire logic       clk_i,       // Clock
   output logic      [7:0] rx_byte_o,   // Byte to slave
   output logic            rx_valid_o,  // Byte strobe
   input  wire logic [7:0] tx_byte_i,   // Reply byte
   input  wire logic       tx_valid_i,  // Reply byte valid
   output logic            tx_ready_o   // Reply byte taken
);
   logic [7:0] rxq[$];
   bit         stall;

   initial begin
      rx_byte_o = 8'h00;
      rx_valid_o = 1'b0;
   end

   // CRC over a byte list, low bit first
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      end
      return c;
   endfunction

   // Send frame, CRC appended low byte first; bad spoils it
   task automatic send(input logic [7:0] f[$], input bit bad);
      logic [15:0] c;
      c = crc16(f) ^ {15'h0000, bad};
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      rxq.delete();
      foreach (f[i]) begin
         @(posedge clk_i);
         #1;
         rx_byte_o = f[i];
         rx_valid_o = 1'b1;
         @(posedge clk_i);
         #1;
         rx_valid_o = 1'b0;
         rx_byte_o = ~f[i];  // Short gap only, well under dead time
      end
   endtask

   // Take reply bytes; optional stall toggles ready
   always @(posedge clk_i) begin
      if (tx_valid_i && tx_ready_o) rxq.push_back(tx_byte_i);
      #1 tx_ready_o <= stall ? ~tx_ready_o : 1'b1;
   end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench of the function-code handler
`timescale 1ns/100ps
module tb_top;
   logic        clk_i, srst_i, any_addr;
   logic [7:0]  rx_byte, tx_byte;
   logic        rx_valid, tx_valid, tx_ready;
   logic [15:0] reg_addr, reg_wdata, reg_rdata;
   logic        reg_we, reg_re, op_rst, op_evt, op_osc;
   logic [63:0] vin;
   logic [15:0] mem [0:255];
   int          failures, n_tests, cyc, n_rst, n_evt, n_osc;

   mfh_function_handler #(.GAP_CYCLES(20)) dut_u (
      .clk_i(clk_i), .srst_i(srst_i), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
      .slave_addr_i(8'h11), .any_addr_i(any_addr), .tx_byte_o(tx_byte),
      .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .reg_we_o(reg_we), .reg_re_o(reg_re),
      .reg_rdata_i(reg_rdata), .op_reset_o(op_rst), .op_clr_events_o(op_evt),
      .op_clr_osc_o(op_osc), .vin_state_o(vin));

   mfh_master_model u_mst (
      .clk_i(clk_i), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
      .tx_byte_i(tx_byte), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

   // Register store, read data valid the cycle after a read pulse
   always @(posedge clk_i) begin
      if (reg_we) mem[reg_addr[7:0]] <= reg_wdata;
      reg_rdata <= reg_re ? mem[reg_addr[7:0]] : ~reg_rdata;
      if (!srst_i) begin
         n_rst += op_rst;
         n_evt += op_evt;
         n_osc += op_osc;
      end
      cyc++;
      if (cyc == 60000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // Request, then compare reply with expected bytes plus CRC
   task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$]);
      logic [15:0] c;
      c = u_mst.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
      u_mst.send(req, 1'b0);
      for (int i = 0; i < 3000 && u_mst.rxq.size() < exp.size(); i++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      check("reply length", u_mst.rxq.size(), exp.size());
      foreach (exp[i]) check("reply byte", u_mst.rxq[i], exp[i]);
   endtask

   // Request that must draw no reply
   task automatic silent(input logic [7:0] req[$], input bit bad);
      u_mst.send(req, bad);
      repeat (80) @(posedge clk_i);
      check("no reply", u_mst.rxq.size(), 0);
   endtask

   task automatic t_read;
      logic [7:0] e[$];
      mem[8'h50] = 16'h0028;
      mem[8'h51] = 16'h012C;
      mem[8'h52] = 16'h0000;
      xact('{8'h11, 8'h04, 8'h40, 8'h50, 8'h00, 8'h03},
           '{8'h11, 8'h04, 8'h06, 8'h00, 8'h28, 8'h01, 8'h2C, 8'h00, 8'h00});
      check("crc low", u_mst.rxq[9], 8'h0D);
      check("crc high", u_mst.rxq[10], 8'h60);
      xact('{8'h11, 8'h03, 8'h40, 8'h50, 8'h00, 8'h01}, '{8'h11, 8'h03, 8'h02, 8'h00, 8'h28});
      e = '{8'h11, 8'h03, 8'hFA};
      for (int i = 0; i < 125; i++) begin
         e.push_back(mem[i][15:8]);
         e.push_back(mem[i][7:0]);
      end
      xact('{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7D}, e);
      xact('{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7E}, '{8'h11, 8'h83, 8'h03});
      xact('{8'h11, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h11, 8'h84, 8'h03});
      u_mst.stall = 1'b1;
      xact('{8'h11, 8'h04, 8'h40, 8'h51, 8'h00, 8'h01}, '{8'h11, 8'h04, 8'h02, 8'h01, 8'h2C});
      u_mst.stall = 1'b0;
      $display("read test done");
   endtask

   task automatic t_exec;
      xact('{8'h11, 8'h05, 8'h00, 8'h01, 8'hFF, 8'h00}, '{8'h11, 8'h05, 8'h00, 8'h01, 8'hFF, 8'h00});
      xact('{8'h11, 8'h05, 8'h00, 8'h05, 8'hFF, 8'h00}, '{8'h11, 8'h05, 8'h00, 8'h05, 8'hFF, 8'h00});
      xact('{8'h11, 8'h05, 8'h00, 8'h06, 8'hFF, 8'h00}, '{8'h11, 8'h05, 8'h00, 8'h06, 8'hFF, 8'h00});
      xact('{8'h11, 8'h05, 8'h00, 8'h00, 8'hFF, 8'h00}, '{8'h11, 8'h05, 8'h00, 8'h00, 8'hFF, 8'h00});
      check("pulse counts", {n_rst[7:0], n_evt[7:0], n_osc[7:0]}, 24'h010101);
      xact('{8'h11, 8'h05, 8'h10, 8'h00, 8'hFF, 8'h00}, '{8'h11, 8'h05, 8'h10, 8'h00, 8'hFF, 8'h00});
      xact('{8'h11, 8'h05, 8'h10, 8'h3F, 8'hFF, 8'h00}, '{8'h11, 8'h05, 8'h10, 8'h3F, 8'hFF, 8'h00});
      check("inputs on", vin, 64'h8000000000000001);
      xact('{8'h11, 8'h05, 8'h10, 8'h00, 8'h00, 8'h00}, '{8'h11, 8'h05, 8'h10, 8'h00, 8'h00, 8'h00});
      check("input off", vin, 64'h8000000000000000);
      xact('{8'h11, 8'h05, 8'h10, 8'h40, 8'hFF, 8'h00}, '{8'h11, 8'h85, 8'h02});
      xact('{8'h11, 8'h05, 8'h00, 8'h01, 8'h12, 8'h34}, '{8'h11, 8'h85, 8'h03});
      check("no stray pulse", n_rst, 1);
      $display("execute test done");
   endtask

   task automatic t_write;
      logic [7:0] big[$];
      xact('{8'h11, 8'h06, 8'h40, 8'h51, 8'h00, 8'hC8}, '{8'h11, 8'h06, 8'h40, 8'h51, 8'h00, 8'hC8});
      check("single store", mem[8'h51], 16'h00C8);
      xact('{8'h11, 8'h10, 8'h40, 8'h60, 8'h00, 8'h02, 8'h04, 8'h00, 8'hC8, 8'h00, 8'h01},
           '{8'h11, 8'h10, 8'h40, 8'h60, 8'h00, 8'h02});
      check("multi store", {mem[8'h60], mem[8'h61]}, 32'h00C80001);
      big = '{8'h11, 8'h10, 8'h00, 8'h80, 8'h00, 8'h3D, 8'h7A};
      for (int i = 0; i < 122; i++) big.push_back(8'hA5);
      xact(big, '{8'h11, 8'h90, 8'h03});
      check("no partial store", mem[8'h80], 16'h0080);
      // Sixty registers is the largest write still accepted
      big = '{8'h11, 8'h10, 8'h00, 8'hC0, 8'h00, 8'h3C, 8'h78};
      for (int i = 0; i < 120; i++) big.push_back(8'hA5);
      xact(big, '{8'h11, 8'h10, 8'h00, 8'hC0, 8'h00, 8'h3C});
      check("sixty stored", {mem[8'hC0], mem[8'hFB]}, 32'hA5A5A5A5);
      $display("write test done");
   endtask

   task automatic t_error;
      xact('{8'h11, 8'h39}, '{8'h11, 8'hB9, 8'h01});
      xact('{8'h11, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h11, 8'h81, 8'h01});
      silent('{8'h11, 8'h06, 8'h00, 8'h90, 8'h12, 8'h34}, 1'b1);
      check("bad crc store", mem[8'h90], 16'h0090);
      silent('{8'h00, 8'h05, 8'h00, 8'h01, 8'hFF, 8'h00}, 1'b0);
      check("broadcast acts", n_rst, 2);
      silent('{8'h00, 8'h06, 8'h00, 8'h91, 8'h12, 8'h34}, 1'b0);
      check("broadcast ignored", mem[8'h91], 16'h0091);
      silent('{8'h12, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
      #1 any_addr = 1'b1;
      xact('{8'h12, 8'h04, 8'h00, 8'h01, 8'h00, 8'h01}, '{8'h12, 8'h04, 8'h02, 8'h00, 8'h01});
      #1 any_addr = 1'b0;
      $display("error test done");
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   initial begin
      srst_i = 1'b1;
      any_addr = 1'b0;
      foreach (mem[i]) mem[i] = 16'(i);
      repeat (12) @(posedge clk_i);
      #1 srst_i = 1'b0;
      check("vin after reset", vin, 64'h0);
      t_read();
      t_exec();
      t_write();
      t_error();
      end_of_test();
   end
endmodule
